// ---- verilog/tap_port.sv ----
// Test access port controller with pin pull-up and mux defaults
// Summary of operation
// - Test reset high hands the device over to the scan system.
// - Test reset low or open keeps functional mode and the controller reset.
// - Mode select steps the controller on each rising test clock edge.
// - Data input enters the selected register on a rising test clock edge.
// - Selected register shifts out on the falling test clock edge.
// - After reset all pins except test port pins select general purpose.
// - Each general purpose pin has a pull-up enable set or cleared individually.
// - Pull-ups reset off on PWM pins, on for all other pins.
// - Test clock, mode select and data input pins keep pull-ups on.
`timescale 1ns/1ps
module tap_port (
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       nrst,
   // Test port pins
   input  wire logic                       tck,
   input  wire logic                       tms,
   input  wire logic                       tdi,
   input  wire logic                       trst,
   output logic                            tdo,
   output logic                            tdo_oe_n,
   // Mode and pin pull-ups of the test port
   output logic                            scan_ctl,
   output logic      [2:0]                 tap_pu,
   // Pin configuration from the core
   input  wire logic [tap_pkg::GPIO_N-1:0] pu_set,
   input  wire logic [tap_pkg::GPIO_N-1:0] pu_clr,
   input  wire logic [tap_pkg::GPIO_N-1:0] alt_set,
   input  wire logic [tap_pkg::GPIO_N-1:0] alt_clr,
   output logic      [tap_pkg::GPIO_N-1:0] pu_en,
   output logic      [tap_pkg::GPIO_N-1:0] mux_alt
);
   import tap_pkg::*;

   typedef struct packed {
      tap_fsm_t          fsm;
      logic              tck_q;
      logic [IR_W-1:0]   ir;
      logic [IR_W-1:0]   ir_sr;
      logic [DR_W-1:0]   dr_sr;
      logic              tdo;
      logic              tdo_oe_n;
      logic              scan_ctl;
      logic [2:0]        tap_pu;
      logic [GPIO_N-1:0] pu_en;
      logic [GPIO_N-1:0] mux_alt;
   } tap_state_t;

   localparam tap_state_t ST_RST = '{fsm: TAP_RESET, tck_q: 1'b0, ir: IR_RST, ir_sr: '0, dr_sr: '0,
                                     tdo: 1'b0, tdo_oe_n: 1'b1, scan_ctl: 1'b0, tap_pu: TAP_PU,
                                     pu_en: PU_RST, mux_alt: ALT_RST};

   tap_state_t        st;
   tap_state_t        next_st;
   logic [SYNC_W-1:0] pins_s;
   logic              tck_s;
   logic              tms_s;
   logic              tdi_s;
   logic              trst_s;
   logic              rise;
   logic              fall;

   // Controller transition table
   function automatic tap_fsm_t tap_next(input tap_fsm_t s, input logic m);
      unique case (s)
         TAP_RESET:    tap_next = m ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:     tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR:   tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR:   tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
         TAP_UPD_DR:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR:   tap_next = m ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR:   tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
         TAP_UPD_IR:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      endcase
   endfunction

   function automatic logic is_shift(input tap_fsm_t s);
      is_shift = (s == TAP_SHIFT_DR) || (s == TAP_SHIFT_IR);
   endfunction

   // Pins are asynchronous to sys_clk; all logic reads the settled copies
   tap_sync tap_sync_i (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .din     ({trst, tdi, tms, tck}),
      .dout    (pins_s)
   );

   assign tck_s  = pins_s[LN_TCK];
   assign tms_s  = pins_s[LN_TMS];
   assign tdi_s  = pins_s[LN_TDI];
   assign trst_s = pins_s[LN_TRST];
   // Test clock runs far slower than sys_clk, so its edges are found by sampling
   // Detection costs two sys_clk of latency: a test clock phase shorter than one sys_clk can be lost
   assign rise   = tck_s & ~st.tck_q;
   assign fall   = ~tck_s & st.tck_q;

   always_comb begin
      next_st          = st;
      next_st.tck_q    = tck_s;
      next_st.scan_ctl = trst_s;
      next_st.tap_pu   = TAP_PU;
      if (!trst_s) begin
         // Functional mode: controller held in reset, pins released
         next_st.fsm      = TAP_RESET;
         next_st.ir       = IR_RST;
         next_st.tdo_oe_n = 1'b1;
      end else begin
         if (rise) begin
            unique case (st.fsm)
               TAP_CAP_DR:   next_st.dr_sr = (st.ir == IR_IDCODE) ? ID_WORD : '0;
               TAP_SHIFT_DR: next_st.dr_sr = (st.ir == IR_IDCODE) ?
                                            {tdi_s, st.dr_sr[DR_W-1:1]} : {{(DR_W-1){1'b0}}, tdi_s};
               TAP_CAP_IR:   next_st.ir_sr = IR_CAPTURE;
               TAP_SHIFT_IR: next_st.ir_sr = {tdi_s, st.ir_sr[IR_W-1:1]};
               TAP_UPD_IR:   next_st.ir    = st.ir_sr;
               TAP_RESET:    next_st.ir    = IR_RST;
               default:      next_st.ir    = st.ir;
            endcase
            next_st.fsm = tap_next(st.fsm, tms_s);
         end
         if (fall) begin
            next_st.tdo      = (st.fsm == TAP_SHIFT_IR) ? st.ir_sr[0] : st.dr_sr[0];
            next_st.tdo_oe_n = ~is_shift(st.fsm);
         end
      end
      // Set wins over clear when both arrive together
      next_st.pu_en   = (st.pu_en & ~pu_clr) | pu_set;
      // Test port pins keep their dedicated function
      next_st.mux_alt = ((st.mux_alt & ~alt_clr) | alt_set) | TAP_PINS;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   assign tdo      = st.tdo;
   assign tdo_oe_n = st.tdo_oe_n;
   assign scan_ctl = st.scan_ctl;
   assign tap_pu   = st.tap_pu;
   assign pu_en    = st.pu_en;
   assign mux_alt  = st.mux_alt;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_rise_shift_dr;
      rise ##0 trst_s ##0 (st.fsm == TAP_SHIFT_DR) ##0 (st.ir == IR_IDCODE);
   endsequence

   sequence s_fall_idle;
      fall ##0 trst_s ##0 !is_shift(st.fsm);
   endsequence

   // Any instruction other than the identity one selects the one-bit bypass register
   sequence s_rise_shift_byp;
      rise ##0 trst_s ##0 (st.fsm == TAP_SHIFT_DR) ##0 (st.ir != IR_IDCODE);
   endsequence

   sequence s_fall_shift;
      fall ##0 trst_s ##0 is_shift(st.fsm);
   endsequence

   sequence s_fall_shift_dr;
      fall ##0 trst_s ##0 (st.fsm == TAP_SHIFT_DR);
   endsequence

   sequence s_rise_upd_ir;
      rise ##0 trst_s ##0 (st.fsm == TAP_UPD_IR);
   endsequence

   a_scan_handover: assert property (trst_s |=> scan_ctl)
      else $error("scan control not granted while test reset high");

   a_func_mode: assert property (!trst_s |=> (st.fsm == TAP_RESET) && !scan_ctl && tdo_oe_n)
      else $error("controller not held in reset in functional mode");

   a_tms_step: assert property ((rise && trst_s) |=> st.fsm == tap_next($past(st.fsm), $past(tms_s)))
      else $error("controller did not follow mode select");

   a_tdi_capture: assert property (s_rise_shift_dr |=> st.dr_sr[DR_W-1] == $past(tdi_s))
      else $error("data input not captured on rising edge");

   a_tdo_on_fall: assert property (!fall |=> $stable(tdo))
      else $error("data output changed away from a falling edge");

   a_tdo_hiz: assert property (s_fall_idle |=> tdo_oe_n [*2])
      else $error("data output driven outside a shift state");

   a_pu_set_wins: assert property ((|pu_set) |=> ((pu_en & $past(pu_set)) == $past(pu_set)))
      else $error("pull-up set request lost");

   a_tap_pins_mux: assert property ((mux_alt & TAP_PINS) == TAP_PINS)
      else $error("test port pin left its dedicated function");

   a_tap_pullups: assert property (tap_pu == TAP_PU)
      else $error("test port pull-up dropped");

   a_bypass_capture: assert property (s_rise_shift_byp |=> st.dr_sr[0] == $past(tdi_s))
      else $error("data input not captured into bypass register");

   a_tdo_dr_bit: assert property (s_fall_shift_dr |=> tdo == $past(st.dr_sr[0]))
      else $error("data output not taken from the data register");

   a_tdo_drive: assert property (s_fall_shift |=> !tdo_oe_n)
      else $error("data output not driven while shifting");

   a_pu_clear: assert property ((|(pu_clr & ~pu_set)) |=> ((pu_en & $past(pu_clr & ~pu_set)) == '0))
      else $error("pull-up clear request lost");

   a_ir_update: assert property (s_rise_upd_ir |=> st.ir == $past(st.ir_sr))
      else $error("instruction not updated");

endmodule // tap_port

// ---- inc/tap_pkg.sv ----
// Constants and types shared by the test access port block
package tap_pkg;

   // Pin counts and widths
   localparam int unsigned GPIO_N   = 42;
   localparam int unsigned IR_W     = 4;
   localparam int unsigned DR_W     = 32;
   localparam int unsigned SYNC_W   = 4;

   // Multiplexed pins carrying the test port lines
   localparam int unsigned PIN_TDI  = 35;
   localparam int unsigned PIN_TMS  = 36;
   localparam int unsigned PIN_TDO  = 37;
   localparam int unsigned PIN_TCK  = 38;

   // Synchroniser lane positions
   localparam int unsigned LN_TCK   = 0;
   localparam int unsigned LN_TMS   = 1;
   localparam int unsigned LN_TDI   = 2;
   localparam int unsigned LN_TRST  = 3;

   // Instruction codes
   localparam logic [IR_W-1:0] IR_IDCODE  = 4'h1;
   localparam logic [IR_W-1:0] IR_BYPASS  = 4'hf;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   localparam logic [IR_W-1:0] IR_RST     = 4'h1;

   // Identification word: arbitrary value
   localparam logic [DR_W-1:0] ID_WORD    = 32'h0000_5a5b;

   // Reset values of the pin configuration
   localparam logic [GPIO_N-1:0] PWM_PINS = 42'h000_0000_00ff;
   localparam logic [GPIO_N-1:0] PU_RST   = ~PWM_PINS;
   localparam logic [GPIO_N-1:0] TAP_PINS = 42'h078_0000_0000;
   localparam logic [GPIO_N-1:0] ALT_RST  = TAP_PINS;
   localparam logic [2:0]        TAP_PU   = 3'h7;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
      TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } tap_fsm_t;

endpackage

// ---- verilog/tap_sync.sv ----
// Two-stage synchroniser for the asynchronous test port pins
`timescale 1ns/1ps
module tap_sync (
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       nrst,
   // Pin levels in and settled levels out
   input  wire logic [tap_pkg::SYNC_W-1:0] din,
   output logic      [tap_pkg::SYNC_W-1:0] dout
);
   import tap_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] meta;
      logic [SYNC_W-1:0] held;
   } tap_sync_t;

   tap_sync_t st;
   tap_sync_t next_st;

   // Only the second stage is read, so a metastable first stage never reaches logic
   always_comb begin
      next_st      = st;
      next_st.meta = din;
      next_st.held = st.meta;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.held;
endmodule // tap_sync

// ---- tb/tap_probe.sv ----
// Behavioural debug probe that drives the test port pins
`timescale 1ns/1ps
module tap_probe (
   // Clock that paces the pin changes
   input  wire logic sys_clk,
   // Test port pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      trst,
   input  wire logic tdo
);
   // Test clock stands low between frames
   initial begin
      tck  = 1'b0;
      tms  = 1'b1;
      tdi  = 1'b1;
      trst = 1'b0;
   end

   // One 160 ns test clock period, eight sys_clk low and eight high; data out is read just before the rise
   task automatic step(input logic m, input logic d, output logic o);
      @(negedge sys_clk);
      tms = m;
      tdi = d;
      repeat (7) @(negedge sys_clk);
      o   = tdo;
      tck = 1'b1;
      repeat (8) @(negedge sys_clk);
      tck = 1'b0;
   endtask

   task automatic set_trst(input logic v);
      @(negedge sys_clk);
      trst = v;
   endtask
endmodule // tap_probe

// ---- tb/test_test_access_pin_interface.sv ----
// Self-checking bench for the test access port block
`timescale 1ns/1ps
module test_test_access_pin_interface;
   import tap_pkg::*;
   logic              sys_clk, nrst, tck, tms, tdi, trst, tdo, tdo_oe_n, scan_ctl;
   logic [2:0]        tap_pu;
   logic [GPIO_N-1:0] pu_set, pu_clr, alt_set, alt_clr, pu_en, mux_alt;
   wire               tdo_pin;
   int                err_total, cmp_count;

   // No pull on this line, so a released output reads as high impedance
   assign tdo_pin = tdo_oe_n ? 1'bz : tdo;

   tap_port tap_port_i (.sys_clk, .nrst, .tck, .tms, .tdi, .trst, .tdo, .tdo_oe_n, .scan_ctl,
                        .tap_pu, .pu_set, .pu_clr, .alt_set, .alt_clr, .pu_en, .mux_alt);
   tap_probe tap_probe_i (.sys_clk, .tck, .tms, .tdi, .trst, .tdo(tdo_pin));

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask

   task automatic finish_test();
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic nav(input logic [7:0] seq, input int n);
      logic o;
      for (int i = 0; i < n; i++) begin
         tap_probe_i.step(seq[i], 1'b0, o);
      end
   endtask

   // Last bit leaves the shift state
   task automatic shift(input int n, input logic [39:0] din, output logic [39:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         tap_probe_i.step(i == n - 1, din[i], dout[i]);
      end
   endtask

   task automatic reset_values();
      chk(pu_en, PU_RST, "pull-up reset");
      chk(mux_alt, ALT_RST, "mux reset");
      chk(tap_pu, TAP_PU, "test pin pull-ups");
      chk(scan_ctl, 0, "scan control idle");
      chk(tdo_oe_n, 1, "data out released");
   endtask

   task automatic pin_config();
      logic [GPIO_N-1:0] exp;
      @(negedge sys_clk);
      pu_clr[10] = 1'b1;
      pu_set[0]  = 1'b1;
      pu_set[2]  = 1'b1;
      pu_clr[2]  = 1'b1;
      alt_set[9] = 1'b1;
      @(negedge sys_clk);
      pu_clr     = '0;
      pu_set     = '0;
      alt_set[9] = 1'b0;
      alt_set[5] = 1'b1;
      alt_clr    = '1;
      exp     = PU_RST;
      exp[10] = 1'b0;
      exp[0]  = 1'b1;
      exp[2]  = 1'b1;
      chk(pu_en, exp, "pull-up set and clear");
      exp     = TAP_PINS;
      exp[9]  = 1'b1;
      chk(mux_alt, exp, "mux set");
      @(negedge sys_clk);
      alt_clr = '0;
      alt_set = '0;
      exp     = TAP_PINS;
      exp[5]  = 1'b1;
      chk(mux_alt, exp, "mux select");
   endtask

   // Reset in mid-run must restore the pin configuration changed above
   task automatic reset_again();
      @(negedge sys_clk);
      nrst = 1'b0;
      repeat (2) @(negedge sys_clk);
      nrst = 1'b1;
      reset_values();
   endtask

   task automatic scan_id();
      logic [39:0] got;
      tap_probe_i.set_trst(1'b1);
      repeat (5) @(negedge sys_clk);
      chk(scan_ctl, 1, "scan control");
      nav(8'h02, 4);
      shift(40, 40'ha5, got);
      chk(got, {8'ha5, ID_WORD}, "identity scan");
      repeat (10) @(negedge sys_clk);
      chk(tdo_oe_n, 1, "released after shift");
   endtask

   task automatic scan_bypass();
      logic [39:0] got;
      nav(8'h07, 5);
      shift(4, {36'h0, IR_BYPASS}, got);
      chk(got[3:0], IR_CAPTURE, "instruction capture");
      nav(8'h03, 4);
      shift(3, 40'h5, got);
      chk(got[2:0], 3'h2, "bypass one bit delay");
      nav(8'h02, 3);
      repeat (10) @(negedge sys_clk);
      chk(tdo_oe_n, 0, "driven while shifting");
      tap_probe_i.set_trst(1'b0);
      repeat (6) @(negedge sys_clk);
      chk(scan_ctl, 0, "functional mode");
      chk(tdo_oe_n, 1, "released by test reset");
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      nrst      = 1'b0;
      pu_set    = '0;
      pu_clr    = '0;
      alt_set   = '0;
      alt_clr   = '0;
      err_total = 0;
      cmp_count = 0;
      repeat (12) @(negedge sys_clk);
      nrst = 1'b1;
      reset_values();
      pin_config();
      reset_again();
      scan_id();
      scan_bypass();
      finish_test();
   end

   // Cuts a hang short
   initial begin
      #200000;
      err_total++;
      finish_test();
   end
endmodule // test_test_access_pin_interface
